// ### hw/rep_top.sv
// ROM emulation glue: phase decode, address latch, nibble mux, ports
module rep_top
	import rep_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = rep_pkg::DEBOUNCE_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_cpu_clk,
	input  wire logic        i_sync_n,
	input  wire logic        i_command_line_n,
	input  wire logic [3:0]  i_data,
	input  wire logic [7:0]  i_mem_data,
	input  wire logic [15:0] i_port_in,
	input  wire logic        i_serial_rx,
	input  wire logic        i_reset_btn,
	output logic      [7:0]  o_phase,
	output logic      [7:0]  o_mem_addr,
	output logic      [15:0] o_mem_cs,
	output logic      [3:0]  o_data,
	output logic             o_data_oe,
	output logic      [15:0] o_port_out,
	output logic             o_test,
	output logic             o_cpu_reset,
	output logic             o_clk_stall
);
	import rep_pkg::*;

	function automatic rep_phase_t next_phase(input rep_phase_t p);
		case (p)
			PH_ADDR_FIRST:  next_phase = PH_ADDR_SECOND;
			PH_ADDR_SECOND: next_phase = PH_ADDR_THIRD;
			PH_ADDR_THIRD:  next_phase = PH_MEM_FIRST;
			PH_MEM_FIRST:   next_phase = PH_MEM_SECOND;
			PH_MEM_SECOND:  next_phase = PH_EXEC_FIRST;
			PH_EXEC_FIRST:  next_phase = PH_EXEC_SECOND;
			PH_EXEC_SECOND: next_phase = PH_EXEC_THIRD;
			default:        next_phase = PH_ADDR_FIRST;
		endcase
	endfunction : next_phase

	// Two decoder stages: top bit picks the bank, low bits the chip
	function automatic logic [15:0] chip_select(input logic [3:0] page);
		logic [7:0] dec;
		dec = 8'h01 << page[2:0];
		chip_select = page[3] ? {dec, 8'h00} : {8'h00, dec};
	endfunction : chip_select

	function automatic logic [3:0] port_decode(input logic [1:0] sel);
		port_decode = 4'h1 << sel;
	endfunction : port_decode

	logic [PIN_W-1:0] meta_q;
	logic [PIN_W-1:0] pin_q;
	logic             cclk_prev_q;
	rep_phase_t       phase_q;
	logic [3:0]       page_q;
	logic [1:0]       psel_q;
	logic             rd_q;
	logic             wr_q;
	logic [STALL_W-1:0] stall_q;
	logic             rst_req;

	logic             cclk_s;
	logic             sync_act;
	logic             cmd_act;
	logic             rx_s;
	logic [3:0]       bus_s;
	logic [7:0]       mem_s;
	logic [15:0]      port_s;
	logic             cpu_edge;
	logic             clr;
	logic [3:0]       port_hit;

	// Every pin passes two flip-flops before use
	always_ff @(posedge i_clk) begin
		meta_q <= {i_port_in, i_mem_data, i_data, i_serial_rx, i_command_line_n,
			i_sync_n, i_cpu_clk};
		pin_q  <= meta_q;
	end

	assign cclk_s   = pin_q[PIN_CCLK];
	assign sync_act = ~pin_q[PIN_SYNC_N];
	assign cmd_act  = ~pin_q[PIN_CMD_N];
	assign rx_s     = pin_q[PIN_RX];
	assign bus_s    = pin_q[PIN_DATA +: 4];
	assign mem_s    = pin_q[PIN_MEM +: 8];
	assign port_s   = pin_q[PIN_PORT +: 16];
	assign cpu_edge = cclk_s & ~cclk_prev_q;
	assign clr      = i_rst | o_cpu_reset;
	assign port_hit = port_decode(psel_q); // see [R8]

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cclk_prev_q <= cclk_s; // Pin level, so an idle-high clock gives no false edge
		end else begin
			cclk_prev_q <= cclk_s;
		end
	end

	// Phase counter steps on each rising CPU clock edge, sync realigns it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase_q <= PH_ADDR_FIRST;
		end else if (cpu_edge) begin
			if (sync_act) begin
				phase_q <= PH_ADDR_FIRST; // see [R22]
			end else begin
				phase_q <= next_phase(phase_q); // see [R1]
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_phase <= 8'h01;
		end else begin
			o_phase <= 8'h01 << phase_q; // see [R1]
		end
	end

	// Address nibbles taken as each address phase ends
	always_ff @(posedge i_clk) begin
		if (clr) begin
			o_mem_addr <= ADDR_RST;
			page_q     <= PAGE_RST;
		end else if (cpu_edge) begin
			case (phase_q)
				PH_ADDR_FIRST:  o_mem_addr[ADDR_LO_LSB +: 4] <= bus_s; // see [R2]
				PH_ADDR_SECOND: o_mem_addr[ADDR_HI_LSB +: 4] <= bus_s; // see [R2]
				PH_ADDR_THIRD:  page_q <= bus_s; // see [R2]
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (clr) begin
			o_mem_cs <= chip_select(PAGE_RST);
		end else begin
			o_mem_cs <= chip_select(page_q); // see [R3] see [R4]
		end
	end

	// Bus drive: memory nibbles, or a selected input port on a read
	always_ff @(posedge i_clk) begin
		if (clr) begin
			o_data    <= 4'h0;
			o_data_oe <= 1'b0;
		end else begin
			case (phase_q)
				PH_MEM_FIRST: begin
					o_data    <= mem_s[7:4]; // see [R5]
					o_data_oe <= 1'b1; // see [R6]
				end
				PH_MEM_SECOND: begin
					o_data    <= mem_s[3:0]; // see [R5]
					o_data_oe <= 1'b1; // see [R6]
				end
				PH_EXEC_SECOND: begin
					o_data    <= rd_q ? port_s[{psel_q, 2'b00} +: 4] : 4'h0; // see [R11]
					o_data_oe <= rd_q; // see [R11]
				end
				default: begin
					o_data    <= 4'h0;
					o_data_oe <= 1'b0; // see [R6]
				end
			endcase
		end
	end

	// Port selection loaded by the select instruction
	always_ff @(posedge i_clk) begin
		if (clr) begin
			psel_q <= PSEL_RST;
		end else if (cpu_edge && phase_q == PH_EXEC_SECOND && cmd_act) begin
			psel_q <= bus_s[1:0]; // see [R7]
		end
	end

	// Read and write control, both dropped during the third execute phase
	always_ff @(posedge i_clk) begin
		if (clr || phase_q == PH_EXEC_THIRD) begin
			rd_q <= 1'b0; // see [R12]
		end else if (cpu_edge && phase_q == PH_MEM_SECOND && cmd_act
			&& bus_s == OPA_READ_IN) begin
			rd_q <= 1'b1; // see [R9] see [R10]
		end
	end

	always_ff @(posedge i_clk) begin
		if (clr || phase_q == PH_EXEC_THIRD) begin
			wr_q <= 1'b0; // see [R15]
		end else if (cpu_edge && phase_q == PH_MEM_SECOND && cmd_act
			&& bus_s == OPA_WRITE_OUT) begin
			wr_q <= 1'b1; // see [R9] see [R13]
		end
	end

	// Output latches are kept inverted, as the pins show them
	always_ff @(posedge i_clk) begin
		if (clr) begin
			o_port_out <= PORT_PINS_RST;
		end else if (cpu_edge && phase_q == PH_EXEC_SECOND && wr_q) begin
			for (int i = 0; i < 4; i++) begin
				if (port_hit[i]) begin
					o_port_out[i*4 +: 4] <= ~bus_s; // see [R13] see [R14] see [R16]
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_test <= 1'b0;
		end else begin
			o_test <= rx_s; // see [R21]
		end
	end

	rep_debounce #(
		.STABLE_CYC (DEBOUNCE_CYCLES)
	) u_debounce (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_raw   (i_reset_btn),
		.o_level (rst_req)
	);

	// Reset takes hold only at a sync edge, so it never cuts a cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cpu_reset <= 1'b0;
		end else if (!rst_req) begin
			o_cpu_reset <= 1'b0;
		end else if (cpu_edge && sync_act) begin
			o_cpu_reset <= 1'b1; // see [R17] see [R18]
		end
	end

	// Missing CPU clock flagged after two nominal phase times
	always_ff @(posedge i_clk) begin
		if (i_rst || cpu_edge) begin
			stall_q     <= '0;
			o_clk_stall <= 1'b0;
		end else begin
			if (stall_q < STALL_W'(STALL_CYC)) begin
				stall_q <= stall_q + 1'b1;
			end
			o_clk_stall <= (stall_q >= STALL_W'(STALL_CYC)); // see [R19]
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	phase_onehot_a: assert property ($onehot(o_phase)) // see [R1]
		else $error("phase decode not one-hot");

	phase_step_a: assert property (
		cpu_edge && !sync_act && phase_q == PH_MEM_FIRST |=>
		phase_q == PH_MEM_SECOND ##1 o_phase == 8'h10) // see [R1]
		else $error("phase did not step from first memory phase");

	sync_align_a: assert property (
		cpu_edge && sync_act |=> phase_q == PH_ADDR_FIRST) // see [R22]
		else $error("sync did not realign phase");

	addr_low_a: assert property (
		!clr && cpu_edge && phase_q == PH_ADDR_FIRST |=>
		o_mem_addr[3:0] == $past(bus_s)) // see [R2]
		else $error("low address nibble not captured");

	cs_decode_a: assert property (
		!clr && cpu_edge && phase_q == PH_ADDR_THIRD ##1 !clr |=>
		o_mem_cs == (16'h0001 << $past(bus_s, 2))) // see [R3]
		else $error("chip select does not match third nibble");

	cs_onehot_a: assert property ($onehot(o_mem_cs)) // see [R4]
		else $error("chip select not one-hot");

	bus_release_a: assert property (
		o_data_oe |-> $past(phase_q) inside {PH_MEM_FIRST, PH_MEM_SECOND}
		|| ($past(phase_q) == PH_EXEC_SECOND && $past(rd_q))) // see [R6]
		else $error("bus driven outside allowed phases");

	nibble_mux_a: assert property (
		!clr && phase_q == PH_MEM_FIRST |=> o_data_oe && o_data == $past(mem_s[7:4])) // see [R5]
		else $error("first memory nibble wrong");

	port_select_a: assert property (
		!clr && cpu_edge && phase_q == PH_EXEC_SECOND && cmd_act |=>
		psel_q == $past(bus_s[1:0])) // see [R7]
		else $error("port select not loaded");

	read_set_a: assert property (
		!clr && cpu_edge && phase_q == PH_MEM_SECOND && cmd_act
		&& bus_s == OPA_READ_IN |=> rd_q) // see [R10]
		else $error("read control not set");

	ctrl_clear_a: assert property (
		phase_q == PH_EXEC_THIRD |=> !rd_q && !wr_q) // see [R12]
		else $error("port control not cleared in third execute phase");

	port_write_a: assert property (
		!clr && cpu_edge && phase_q == PH_EXEC_SECOND && wr_q ##1 !clr |->
		o_port_out[{$past(psel_q), 2'b00} +: 4] == ~$past(bus_s)) // see [R16]
		else $error("output port not inverted latch of bus");

	test_route_a: assert property (!$past(i_rst) |-> o_test == $past(rx_s)) // see [R21]
		else $error("test output does not follow serial line");

	reset_sync_a: assert property (
		$rose(o_cpu_reset) |-> $past(cpu_edge) && $past(sync_act)) // see [R17]
		else $error("reset not aligned to sync");

endmodule : rep_top

// ### hw/rep_pkg.sv
// Constants and types for the ROM emulation port logic
// Operation
// [R1] Eight instruction phases, decoded one-of-eight
// [R2] Three address nibbles latched in address phases
// [R3] Two nibbles address memory, third selects chip
// [R4] Chip selects decode sixteen chips, two stages
// [R5] Memory byte returned as two nibbles
// [R6] Drive bus from memory only in memory phases
// [R7] Command at second execute loads port select
// [R8] Port select decodes into four select lines
// [R9] Port operation: command plus opcode at second memory
// [R10] Read-input opcode sets read-control flip-flop
// [R11] Read control gates input port in exec two
// [R12] Read control clears in third execute phase
// [R13] Write-output opcode sets write-control flip-flop
// [R14] Exec two loads selected output latch, held
// [R15] Write control clears in third execute phase
// [R16] Output pins show inverted latch data
// [R17] Reset applied in step with cycle sync
// [R18] Manual reset debounced before clearing system
// [R19] Clock period 1.35 us, eight per cycle
// [R20] Serial frame eleven bits of 9.09 ms
// [R21] Serial receive line routed to test input
// [R22] Sync pulse realigns phase counter to first address
package rep_pkg;

	localparam int          CLK_PERIOD_NS  = 5;
	localparam int          CPU_PHASE_NS   = 1350;
	localparam int          CPU_CYCLE_NS   = 10800;
	localparam int          CPU_PHASE_CYC  = CPU_PHASE_NS / CLK_PERIOD_NS;
	localparam int          STALL_CYC      = 2 * CPU_PHASE_CYC;
	localparam int          STALL_W        = 10;
	localparam int          DEBOUNCE_NS    = 5000000;
	localparam int          DEBOUNCE_CYC   = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [3:0]  OPA_READ_IN    = 4'ha;
	localparam logic [3:0]  OPA_WRITE_OUT  = 4'h2;

	localparam int          PIN_CCLK       = 0;
	localparam int          PIN_SYNC_N     = 1;
	localparam int          PIN_CMD_N      = 2;
	localparam int          PIN_RX         = 3;
	localparam int          PIN_DATA       = 4;
	localparam int          PIN_MEM        = 8;
	localparam int          PIN_PORT       = 16;
	localparam int          PIN_W          = 32;

	localparam int          ADDR_LO_LSB    = 0;
	localparam int          ADDR_HI_LSB    = 4;
	localparam logic [15:0] PORT_PINS_RST  = 16'hffff;
	localparam logic [7:0]  ADDR_RST       = 8'h00;
	localparam logic [3:0]  PAGE_RST       = 4'h0;
	localparam logic [1:0]  PSEL_RST       = 2'h0;

	typedef enum logic [2:0] {
		PH_ADDR_FIRST,
		PH_ADDR_SECOND,
		PH_ADDR_THIRD,
		PH_MEM_FIRST,
		PH_MEM_SECOND,
		PH_EXEC_FIRST,
		PH_EXEC_SECOND,
		PH_EXEC_THIRD
	} rep_phase_t;

endpackage : rep_pkg

// ### hw/rep_debounce.sv
// Debouncer for the manual reset switch
module rep_debounce #(
	parameter int STABLE_CYC = 1000000
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_raw,
	output logic      o_level
);
	localparam int CW = $clog2(STABLE_CYC + 1);

	logic          meta_q;
	logic          raw_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge i_clk) begin
		meta_q <= i_raw;
		raw_q  <= meta_q;
	end

	// Level only follows after it has held steady for the whole window
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q   <= '0;
			o_level <= 1'b0;
		end else if (raw_q == o_level) begin
			cnt_q <= '0;
		end else if (cnt_q >= CW'(STABLE_CYC - 1)) begin
			cnt_q   <= '0;
			o_level <= raw_q; // see [R18]
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule : rep_debounce

// ### dv/rep_cpu_model.sv
// Behavioural four-bit CPU that drives the multiplexed bus and phase clock
module rep_cpu_model (
	input  wire logic [7:0] i_phase,
	input  wire logic       i_data_oe,
	input  wire logic [3:0] i_bus,
	output logic            o_cpu_clk,
	output logic            o_sync_n,
	output logic            o_cmd_n,
	output logic            o_drive,
	output logic      [3:0] o_nib,
	output int              o_errs
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		o_cpu_clk = 1'b1;
		o_sync_n  = 1'b1;
		o_cmd_n   = 1'b1;
		o_drive   = 1'b0;
		o_nib     = 4'h0;
		o_errs    = 0;
	end

	// Lines change 20 ns after an edge so the synchronised copy still sees the old value
	task automatic phase(input int idx, input logic drv, input logic [3:0] nib,
			input logic cmd, input logic syn, output logic [3:0] got);
		#20;
		o_drive  = drv;
		o_nib    = nib;
		o_cmd_n  = ~cmd;
		o_sync_n = ~syn;
		#655 o_cpu_clk = 1'b0;
		#675;
		got = i_bus;
		if (idx < 8 && (i_phase !== 8'h01 << idx
				|| (drv && i_data_oe !== 1'b0))) begin
			o_errs++;
			$display("unexpected at %0t: %h vs %h", $time, i_phase, 8'h01 << idx);
		end
		o_cpu_clk = 1'b1;
	endtask : phase

	// Eight phases: three address nibbles, two fetch nibbles, three execute
	task automatic run_cycle(input logic [11:0] addr, input logic cm_m2, input logic cm_x2,
			input logic drv_x2, input logic [3:0] x2_nib, output logic [7:0] byte_got,
			output logic [3:0] x2_got);
		logic [3:0] got;
		for (int i = 0; i < 8; i++) begin
			phase(i, i < 3 || (i == 6 && drv_x2), i < 3 ? addr[4 * i +: 4] : x2_nib,
				(i == 4 && cm_m2) || (i == 6 && cm_x2), i == 7, got);
			if (i == 3)
				byte_got[7:4] = got;
			if (i == 4)
				byte_got[3:0] = got;
			if (i == 6)
				x2_got = got;
		end
	endtask : run_cycle

	// Unchecked phases out of step with the device, the last one carrying sync
	task automatic stray(input int n);
		logic [3:0] got;
		for (int i = 1; i <= n; i++)
			phase(8, 1'b0, 4'h0, 1'b0, i == n, got);
	endtask : stray

endmodule : rep_cpu_model

// ### dv/tb_rep_top.sv
// Self-checking bench for the ROM emulation port logic
module tb_rep_top;
	import rep_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int DEB = 16;

	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        btn     = 1'b0;
	logic        rx      = 1'b1;
	logic [15:0] port_in = 16'h96c3;
	logic [15:0] exp_out = 16'hffff;
	logic [3:0]  last_q  = 4'h0;
	logic [7:0]  mem_data, phase, mem_addr, byte_got;
	logic [15:0] mem_cs, port_out;
	logic [3:0]  bus, d_out, nib, x2_got, h, l, v;
	logic        d_oe, test, cpu_reset, stall, cpu_clk, sync_n, cmd_n, drv;
	int          errs, mismatches, num_checks;

	always #2.5 clk = ~clk;

	// An undriven bus shows a changing pattern rather than its last value
	always @(posedge clk) last_q <= bus;
	assign bus = d_oe ? d_out : drv ? nib : ~last_q;

	// Memory array: low byte of address, high nibble mixed with the page
	always_comb begin
		mem_data = mem_addr;
		for (int p = 0; p < 16; p++)
			if (mem_cs[p])
				mem_data[7:4] = mem_addr[7:4] ^ 4'(p);
	end

	rep_top #(.DEBOUNCE_CYCLES(DEB)) u_dut (
		.i_clk(clk), .i_rst(rst), .i_cpu_clk(cpu_clk), .i_sync_n(sync_n),
		.i_command_line_n(cmd_n), .i_data(bus), .i_mem_data(mem_data),
		.i_port_in(port_in), .i_serial_rx(rx), .i_reset_btn(btn), .o_phase(phase),
		.o_mem_addr(mem_addr), .o_mem_cs(mem_cs), .o_data(d_out), .o_data_oe(d_oe),
		.o_port_out(port_out), .o_test(test), .o_cpu_reset(cpu_reset),
		.o_clk_stall(stall)
	);

	rep_cpu_model u_cpu (
		.i_phase(phase), .i_data_oe(d_oe), .i_bus(bus), .o_cpu_clk(cpu_clk),
		.o_sync_n(sync_n), .o_cmd_n(cmd_n), .o_drive(drv), .o_nib(nib), .o_errs(errs)
	);

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic give_verdict;
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_clk

	// Start the CPU off the sampling edge so no pin moves with the clock
	task automatic cyc(input logic [11:0] a, input logic cm, input logic cx,
			input logic dx, input logic [3:0] n);
		@(posedge clk);
		#1;
		u_cpu.run_cycle(a, cm, cx, dx, n, byte_got, x2_got);
	endtask : cyc

	// Terminal frame at a scaled bit time: idle, start, eight data bits, idle
	task automatic send_frame(input logic [7:0] ch);
		logic [10:0] bits;
		bits = {1'b1, ch, 1'b0, 1'b1};
		for (int i = 0; i < 11; i++) begin
			rx <= bits[i];
			wait_clk(8);
			cmp(16'(test), 16'(bits[i]));
		end
	endtask : send_frame

	initial begin
		wait_clk(3);
		rst <= 1'b0;
		wait_clk(4);
		cmp(16'(phase), 16'h0001);
		cmp(port_out, 16'hffff);
		cmp(16'(cpu_reset), 16'h0000);
		cmp(16'(stall), 16'h0000);
		for (int p = 0; p < 16; p += 3) begin
			h = 4'(15 - p);
			l = 4'(p) ^ 4'h5;
			cyc({4'(p), h, l}, 1'b0, 1'b0, 1'b0, 4'h0);
			cmp(16'(byte_got), {8'h00, h ^ 4'(p), l});
			cmp(16'(mem_addr), {8'h00, h, l});
			cmp(mem_cs, 16'h0001 << p);
		end
		@(posedge clk);
		#1;
		u_cpu.stray(3);
		cyc(12'h4b7, 1'b0, 1'b0, 1'b0, 4'h0);
		cmp(16'(byte_got), 16'h00f7);
		for (int k = 0; k < 4; k++) begin
			v = 4'(4 * k + 1);
			cyc(12'h000, 1'b0, 1'b1, 1'b1, 4'(k));
			cyc(12'h012, 1'b1, 1'b0, 1'b1, v);
			exp_out[4 * k +: 4] = ~v;
			cmp(port_out, exp_out);
			cyc(12'h02a, 1'b1, 1'b0, 1'b0, 4'h0);
			cmp(16'(x2_got), 16'(port_in[4 * k +: 4]));
			cmp(port_out, exp_out);
		end
		cyc(12'h023, 1'b1, 1'b0, 1'b1, 4'h6);
		cmp(port_out, exp_out);
		wait_clk(1);
		rx <= 1'b0;
		wait_clk(5);
		cmp(16'(test), 16'h0000);
		rx <= 1'b1;
		wait_clk(5);
		cmp(16'(test), 16'h0001);
		send_frame(8'h5a);
		btn <= 1'b1;
		wait_clk(DEB + 10);
		cmp(16'(cpu_reset), 16'h0000);
		cmp(16'(stall), 16'h0000);
		cyc(12'h000, 1'b0, 1'b0, 1'b0, 4'h0);
		wait_clk(6);
		cmp(16'(cpu_reset), 16'h0001);
		cmp(port_out, 16'hffff);
		btn <= 1'b0;
		wait_clk(DEB + 10);
		cmp(16'(cpu_reset), 16'h0000);
		wait_clk(STALL_CYC);
		cmp(16'(stall), 16'h0001);
		cyc(12'h000, 1'b0, 1'b0, 1'b0, 4'h0);
		cmp(16'(stall), 16'h0000);
		cmp(16'(errs), 16'h0000);
		give_verdict();
	end

	// About 23 instruction cycles of 10.8 us are expected
	initial begin
		#400us;
		mismatches++;
		give_verdict();
	end

endmodule : tb_rep_top
